// >>> src/pfsq_sequencer.sv
// Purpose: pfc enable/disable, skip, hiccup and thermal fault sequencing
// Assumes: comparator results arrive as asynchronous digital levels
// Notes: zero-wait AHB-Lite slave, always OKAY; unmapped reads give zero
`timescale 1ns/1ps
module pfsq_sequencer
	import pfsq_pkg::*;
#(
	parameter int unsigned DIS_CYC = 32'(DISABLE_DELAY_CYC),
	parameter int unsigned EN_CYC = 32'(ENABLE_FILTER_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ss_done,
	input wire logic load_above_off,
	input wire logic load_above_on,
	input wire logic ctrl_below_skip,
	input wire logic ctrl_above_resume,
	input wire logic pfc_in_reg,
	input wire logic pfc_uvp,
	input wire logic vcc_above_on,
	input wire logic vcc_below_off,
	input wire logic vcc_below_clear,
	input wire logic overload,
	input wire logic therm_hot,
	input wire logic therm_cool,
	input wire logic brownout,
	input wire logic line_present,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic controller_enable,
	output logic pfc_enable,
	output logic pfc_switch_enable,
	output logic ctrl_node_pulldown,
	output logic thermal_fault
);
	logic [N_SYNC-1:0] sync_w;
	logic ss_s;
	logic load_off_ok_s;
	logic load_on_ok_s;
	logic ctrl_below_s;
	logic ctrl_above_s;
	logic in_reg_s;
	logic uvp_s;
	logic vcc_on_s;
	logic vcc_off_s;
	logic vcc_clear_s;
	logic overload_s;
	logic hot_s;
	logic cool_s;
	logic brownout_s;
	logic line_s;

	pfsq_state_e st_q;
	pfsq_state_e st_d;
	logic vcc_on_d_q;
	logic fell_q;
	logic fell_d;
	logic [1:0] hic_cnt_q;
	logic [1:0] hic_cnt_d;
	logic therm_q;
	logic therm_d;
	logic [DIS_CNT_W-1:0] dis_cnt_q;
	logic [DIS_CNT_W-1:0] dis_cnt_d;
	logic [EN_CNT_W-1:0] en_cnt_q;
	logic [EN_CNT_W-1:0] en_cnt_d;
	logic pfc_on_q;
	logic pfc_on_d;
	logic reg_seen_q;
	logic reg_seen_d;
	logic skip_q;
	logic skip_d;
	logic ctrl_en_q;
	logic sw_en_q;
	logic pulldown_q;
	logic auto_rec_q;
	logic hready_q;
	logic hresp_q;
	logic [31:0] hrdata_q;
	logic wr_pend_q;
	logic [31:0] wr_addr_q;

	// every comparator level is a pin: two flops before any use
	pfsq_sync #(
		.W(N_SYNC)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({ss_done, load_above_off, load_above_on, ctrl_below_skip, ctrl_above_resume,
			pfc_in_reg, pfc_uvp, vcc_above_on, vcc_below_off, vcc_below_clear, overload,
			therm_hot, therm_cool, brownout, line_present}),
		.q(sync_w)
	);

	assign {ss_s, load_off_ok_s, load_on_ok_s, ctrl_below_s, ctrl_above_s,
		in_reg_s, uvp_s, vcc_on_s, vcc_off_s, vcc_clear_s, overload_s,
		hot_s, cool_s, brownout_s, line_s} = sync_w;

	// supply sequencing
	wire run = (st_q == ST_RUN);
	wire vcc_on_rise = vcc_on_s & ~vcc_on_d_q;
	wire clear_evt = vcc_clear_s | brownout_s | ~line_s;
	wire faults_gone = ~brownout_s & line_s & ~therm_q & ~hot_s;
	wire hic_done = vcc_on_rise & fell_q & (hic_cnt_q == HICCUP_COUNT - 2'h1);

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_WAIT:
			begin
				if (vcc_on_rise && faults_gone)
					st_d = ST_RUN;
			end
			ST_RUN:
			begin
				if (hot_s)
					st_d = ST_THERMAL;
				else if (vcc_off_s)
					st_d = ST_HICCUP;
				else if (overload_s)
					st_d = auto_rec_q ? ST_HICCUP : ST_LATCH;
			end
			ST_HICCUP:
			begin
				if (hot_s)
					st_d = ST_THERMAL;
				else if (hic_done)
					st_d = ST_RUN;
			end
			ST_THERMAL:
			begin
				if (clear_evt && !hot_s)
					st_d = ST_WAIT;
				else if (vcc_on_rise && cool_s)
					st_d = ST_RUN;
			end
			ST_LATCH:
			begin
				// latched stop only leaves through the supply clear level, brown-out or line removal
				if (clear_evt)
					st_d = ST_WAIT;
			end
			default:
				st_d = ST_WAIT;
		endcase
	end

	// a hiccup is a fall to the stop level then a rise through the start level
	assign fell_d = (st_q != ST_HICCUP) ? vcc_off_s :
		(vcc_on_rise ? 1'b0 : (fell_q | vcc_off_s));
	assign hic_cnt_d = (st_q != ST_HICCUP) ? 2'h0 :
		((vcc_on_rise && fell_q) ? hic_cnt_q + 2'h1 : hic_cnt_q);
	// set wins over clear: a hot reading keeps the fault latched
	assign therm_d = (hot_s && st_q != ST_WAIT && st_q != ST_LATCH) |
		(therm_q & ~(st_q == ST_THERMAL && st_d != ST_THERMAL));

	// pfc on/off: start enabled, decisions frozen until soft start ends
	wire start = (st_d == ST_RUN) && !run;
	wire decide = run & ss_s;
	// optocoupler grounding the pin simply reads as below the reference
	wire dis_cond = decide & pfc_on_q & ~load_off_ok_s;
	wire dis_exp = dis_cond && (dis_cnt_q == DIS_CNT_W'(DIS_CYC - 1));
	wire en_cond = decide & ~pfc_on_q & load_on_ok_s;
	wire en_exp = en_cond && (en_cnt_q == EN_CNT_W'(EN_CYC));

	assign dis_cnt_d = (dis_cond && !dis_exp) ? dis_cnt_q + 1'b1 : '0;
	assign en_cnt_d = (en_cond && !en_exp) ? en_cnt_q + 1'b1 : '0;
	assign pfc_on_d = (st_d != ST_RUN) ? 1'b0 :
		start ? 1'b1 :
		dis_exp ? 1'b0 :
		en_exp ? 1'b1 : pfc_on_q;

	// skip: only after regulation is reached in the current pfc run
	assign reg_seen_d = pfc_on_q & (reg_seen_q | in_reg_s);
	wire skip_ok = run & pfc_on_q & reg_seen_q & ~uvp_s;
	assign skip_d = !skip_ok ? 1'b0 :
		ctrl_below_s ? 1'b1 :
		(skip_q && ctrl_above_s) ? 1'b0 : skip_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= ST_WAIT;
			vcc_on_d_q <= 1'b0;
			fell_q <= 1'b0;
			hic_cnt_q <= 2'h0;
			therm_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			vcc_on_d_q <= vcc_on_s;
			fell_q <= fell_d;
			hic_cnt_q <= hic_cnt_d;
			therm_q <= therm_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dis_cnt_q <= '0;
			en_cnt_q <= '0;
			pfc_on_q <= 1'b0;
			reg_seen_q <= 1'b0;
			skip_q <= 1'b0;
		end
		else
		begin
			dis_cnt_q <= dis_cnt_d;
			en_cnt_q <= en_cnt_d;
			pfc_on_q <= pfc_on_d;
			reg_seen_q <= reg_seen_d;
			skip_q <= skip_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_en_q <= 1'b0;
			sw_en_q <= 1'b0;
			pulldown_q <= 1'b1;
		end
		else
		begin
			ctrl_en_q <= (st_d == ST_RUN);
			sw_en_q <= pfc_on_d & ~skip_d;
			pulldown_q <= ~pfc_on_d;
		end
	end

	// AHB-Lite slave, zero wait states
	wire addr_ph = hsel & htrans[1] & hready;
	wire wr_ctrl = wr_pend_q && (wr_addr_q == REG_CTRL_ADDR);
	// a read right behind a write sees the new control value
	wire auto_rec_now = wr_ctrl ? hwdata[CTRL_AUTO_RECOVERY_BIT] : auto_rec_q;
	logic [31:0] stat_w;
	logic [31:0] rd_w;

	always_comb
	begin
		stat_w = 32'h0000_0000;
		stat_w[STAT_CTRL_EN_BIT] = ctrl_en_q;
		stat_w[STAT_PFC_ON_BIT] = pfc_on_q;
		stat_w[STAT_SKIP_BIT] = skip_q;
		stat_w[STAT_THERMAL_BIT] = therm_q;
		stat_w[STAT_HIC_LSB +: 2] = hic_cnt_q;
		stat_w[STAT_STATE_LSB +: 3] = st_q;
		stat_w[STAT_SS_DONE_BIT] = ss_s;
	end

	always_comb
	begin
		rd_w = 32'h0000_0000;
		if (haddr == REG_CTRL_ADDR)
			rd_w[CTRL_AUTO_RECOVERY_BIT] = auto_rec_now;
		else if (haddr == REG_STATUS_ADDR)
			rd_w = stat_w;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
			hrdata_q <= 32'h0000_0000;
			auto_rec_q <= CTRL_AUTO_RECOVERY_RST;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= addr_ph & hwrite;
			wr_addr_q <= addr_ph ? haddr : wr_addr_q;
			hrdata_q <= (addr_ph && !hwrite) ? rd_w : hrdata_q;
			auto_rec_q <= auto_rec_now;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	assign hreadyout = hready_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign controller_enable = ctrl_en_q;
	assign pfc_enable = pfc_on_q;
	assign pfc_switch_enable = sw_en_q;
	assign ctrl_node_pulldown = pulldown_q;
	assign thermal_fault = therm_q;

	property p_freeze;
		@(posedge clk) disable iff (!rst_n)
		(run && !ss_s) ##1 run |-> $stable(pfc_on_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("pfc state moved before soft start end");

	property p_dis;
		@(posedge clk) disable iff (!rst_n)
		(run && $past(run) && $fell(pfc_on_q)) |-> ($past(dis_cnt_q) == DIS_CYC - 1);
	endproperty
	a_dis: assert property (p_dis) else $error("pfc disabled without delay expiry");

	property p_en;
		@(posedge clk) disable iff (!rst_n)
		(run && $past(run) && $rose(pfc_on_q)) |-> ($past(en_cnt_q) == EN_CYC);
	endproperty
	a_en: assert property (p_en) else $error("pfc enabled without full filter time");

	property p_skip_in;
		@(posedge clk) disable iff (!rst_n)
		(skip_ok && ctrl_below_s) |=> skip_q;
	endproperty
	a_skip_in: assert property (p_skip_in) else $error("skip not entered below threshold");

	property p_skip_out;
		@(posedge clk) disable iff (!rst_n)
		$fell(skip_q) |-> ($past(ctrl_above_s) || !$past(skip_ok));
	endproperty
	a_skip_out: assert property (p_skip_out) else $error("skip left below resume level");

	property p_skip_inh;
		@(posedge clk) disable iff (!rst_n)
		(!reg_seen_q || uvp_s) |=> !skip_q;
	endproperty
	a_skip_inh: assert property (p_skip_inh) else $error("skip while inhibited");

	property p_hic;
		@(posedge clk) disable iff (!rst_n)
		(st_q == ST_RUN && $past(st_q) == ST_HICCUP) |-> ($past(hic_cnt_q) == 2'h2);
	endproperty
	a_hic: assert property (p_hic) else $error("restart before three hiccups");

	property p_hot;
		@(posedge clk) disable iff (!rst_n)
		(run && hot_s) |=> (therm_q && !ctrl_en_q) ##1 !ctrl_en_q;
	endproperty
	a_hot: assert property (p_hot) else $error("over-temperature not handled");

	property p_tclr;
		@(posedge clk) disable iff (!rst_n)
		(st_q == ST_THERMAL && clear_evt && !hot_s) |=> !therm_q;
	endproperty
	a_tclr: assert property (p_tclr) else $error("thermal fault not cleared");
endmodule : pfsq_sequencer

// >>> src/pfsq_pkg.sv
// Purpose: constants and types for the pfc enable and fault sequencer
// Assumes: 250 MHz core clock, AHB-Lite register access, 32-bit data
// Notes: long delays become top-level parameters so a bench can shorten them
// How it works
// - pfc on/off decisions are frozen until flyback soft start is done.
// - load sense below disable reference starts disable delay; pfc off on expiry.
// - pfc re-enabled after load sense stays above enable level beyond filter time.
// - skip pfc switching while control node is below the skip threshold.
// - leave skip when control node exceeds threshold plus skip hysteresis, or when skip becomes inhibited.
// - skip inhibited during pfc startup and undervoltage; allowed after regulation.
// - supply below stop level disables controller and enters triple hiccup.
// - overload on auto-recovery variant enters triple hiccup, not latched stop.
// - count hiccups (stop then start crossing); restart after three complete.
// - over-temperature disables controller, latches fault, supply keeps hiccuping.
// - thermal restart at next start crossing once cooled by the hysteresis.
// - thermal fault also cleared by clear level, brown-out or line removal.
// - new power-up only at next start crossing with all faults removed.
// - control node held low while pfc disabled, released when enabled.
package pfsq_pkg;
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam longint unsigned DISABLE_DELAY_MS = 500;
	localparam longint unsigned ENABLE_FILTER_US = 100;
	// longest-type delay rounds down, least-type filter rounds up
	localparam longint unsigned DISABLE_DELAY_CYC =
		(DISABLE_DELAY_MS * 64'd1000000000) / CLK_PERIOD_PS;
	localparam longint unsigned ENABLE_FILTER_CYC =
		(ENABLE_FILTER_US * 64'd1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DIS_CNT_W = 27;
	localparam int EN_CNT_W = 16;
	localparam logic [1:0] HICCUP_COUNT = 2'h3;
	localparam int N_SYNC = 15;

	localparam logic [31:0] REG_CTRL_ADDR = 32'h0000_0000;
	localparam logic [31:0] REG_STATUS_ADDR = 32'h0000_0004;
	localparam int CTRL_AUTO_RECOVERY_BIT = 0;
	localparam logic CTRL_AUTO_RECOVERY_RST = 1'b1;
	localparam int STAT_CTRL_EN_BIT = 0;
	localparam int STAT_PFC_ON_BIT = 1;
	localparam int STAT_SKIP_BIT = 2;
	localparam int STAT_THERMAL_BIT = 3;
	localparam int STAT_HIC_LSB = 4;
	localparam int STAT_STATE_LSB = 6;
	localparam int STAT_SS_DONE_BIT = 9;

	typedef enum logic [2:0] {
		ST_WAIT,
		ST_RUN,
		ST_HICCUP,
		ST_THERMAL,
		ST_LATCH
	} pfsq_state_e;
endpackage : pfsq_pkg

// >>> src/pfsq_sync.sv
// Purpose: two-flop synchroniser for a bundle of comparator levels
// Assumes: inputs are slow levels, not single-cycle pulses
// Notes: bits are synchronised independently
`timescale 1ns/1ps
module pfsq_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end

	assign q = s2_q;
endmodule : pfsq_sync

// >>> sim/pfsq_partner.sv
// Purpose: flyback soft start and secondary optocoupler model
// Assumes: soft start runs only while the controller is enabled
// Notes: soft start restarts on every controller start
`timescale 1ns/1ps
module pfsq_partner #(
	parameter int SS_CYC = 40
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic controller_enable,
	input wire logic opto_on,
	input wire logic lvl_on,
	output logic ss_done,
	output logic load_above_off,
	output logic load_above_on
);
	int ss_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ss_q <= 0;
		else if (!controller_enable)
			ss_q <= 0;
		else if (ss_q < SS_CYC)
			ss_q <= ss_q + 1;
	end
	assign ss_done = (ss_q == SS_CYC);
	// opto grounds the pin, so both comparators read low
	assign load_above_off = !opto_on;
	assign load_above_on = lvl_on && !opto_on;
endmodule : pfsq_partner

// >>> sim/test_pfc_enable_fault_sequencer.sv
// Purpose: self-checking bench for the pfc sequencer
// Assumes: short delay parameters, soft start of 40 cycles
// Notes: waits follow the fixed 3-edge pin-to-output latency
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module test_pfc_enable_fault_sequencer;
	import pfsq_pkg::*;
	logic clk, rst_n, ss_done, load_above_off, load_above_on, ctrl_below_skip, ctrl_above_resume;
	logic pfc_in_reg, pfc_uvp, vcc_above_on, vcc_below_off, vcc_below_clear, overload;
	logic therm_hot, therm_cool, brownout, line_present, hsel, hwrite, opto_on, lvl_on;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, controller_enable, pfc_enable, pfc_switch_enable;
	logic ctrl_node_pulldown, thermal_fault;
	int errors, tests_run, cycles;
	pfsq_sequencer #(.DIS_CYC(20), .EN_CYC(5)) dut (.clk, .rst_n, .ss_done, .load_above_off,
		.load_above_on, .ctrl_below_skip, .ctrl_above_resume, .pfc_in_reg, .pfc_uvp,
		.vcc_above_on, .vcc_below_off, .vcc_below_clear, .overload, .therm_hot, .therm_cool,
		.brownout, .line_present, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .controller_enable, .pfc_enable,
		.pfc_switch_enable, .ctrl_node_pulldown, .thermal_fault);
	pfsq_partner #(.SS_CYC(40)) fb (.clk, .rst_n, .controller_enable, .opto_on, .lvl_on,
		.ss_done, .load_above_off, .load_above_on);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task report_and_stop;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			report_and_stop;
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// non-overlapped transfers keep the master simple
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task vcc_fall;
		vcc_above_on <= 1'b0;
		vcc_below_off <= 1'b1;
		cyc(6);
	endtask : vcc_fall
	task vcc_rise;
		vcc_below_off <= 1'b0;
		cyc(2);
		vcc_above_on <= 1'b1;
		cyc(6);
	endtask : vcc_rise
	task t_regs;
		`CHK("pulldown", 1'b1, ctrl_node_pulldown)
		ahb(1'b0, REG_CTRL_ADDR, 32'h0);
		`CHK("ctrl", 32'h1, rd)
		`CHK("hresp", 1'b0, hresp)
		ahb(1'b1, REG_CTRL_ADDR, 32'h0);
		ahb(1'b0, REG_CTRL_ADDR, 32'h0);
		`CHK("ctrl", 32'h0, rd)
		ahb(1'b0, 32'h10, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		ahb(1'b1, REG_CTRL_ADDR, 32'h1);
	endtask : t_regs
	task t_start;
		vcc_above_on <= 1'b1;
		opto_on <= 1'b1;
		cyc(6);
		`CHK("ctl_en", 1'b1, controller_enable)
		`CHK("pulldown", 1'b0, ctrl_node_pulldown)
		cyc(24);
		`CHK("pfc_en", 1'b1, pfc_enable)
		cyc(25);
		`CHK("pfc_en", 1'b1, pfc_enable)
		cyc(20);
		`CHK("pfc_en", 1'b0, pfc_enable)
		`CHK("pulldown", 1'b1, ctrl_node_pulldown)
	endtask : t_start
	task t_enable;
		opto_on <= 1'b0;
		lvl_on <= 1'b1;
		cyc(4);
		lvl_on <= 1'b0;
		cyc(2);
		lvl_on <= 1'b1;
		cyc(6);
		`CHK("pfc_en", 1'b0, pfc_enable)
		cyc(8);
		`CHK("pfc_en", 1'b1, pfc_enable)
	endtask : t_enable
	task t_skip;
		// regulation not yet reached: skip must stay inhibited
		ctrl_below_skip <= 1'b1;
		cyc(6);
		`CHK("sw_en", 1'b1, pfc_switch_enable)
		pfc_uvp <= 1'b1;
		pfc_in_reg <= 1'b1;
		cyc(6);
		`CHK("sw_en", 1'b1, pfc_switch_enable)
		pfc_uvp <= 1'b0;
		cyc(6);
		`CHK("sw_en", 1'b0, pfc_switch_enable)
		ctrl_below_skip <= 1'b0;
		cyc(6);
		`CHK("sw_en", 1'b0, pfc_switch_enable)
		ctrl_above_resume <= 1'b1;
		cyc(6);
		`CHK("sw_en", 1'b1, pfc_switch_enable)
	endtask : t_skip
	task t_hiccup;
		vcc_fall;
		`CHK("ctl_en", 1'b0, controller_enable)
		vcc_rise;
		vcc_fall;
		vcc_rise;
		`CHK("ctl_en", 1'b0, controller_enable)
		vcc_fall;
		vcc_rise;
		`CHK("ctl_en", 1'b1, controller_enable)
		overload <= 1'b1;
		cyc(6);
		ahb(1'b0, REG_STATUS_ADDR, 32'h0);
		`CHK("state", ST_HICCUP, rd[STAT_STATE_LSB +: 3])
		overload <= 1'b0;
		repeat (3)
		begin
			vcc_fall;
			vcc_rise;
		end
		`CHK("ctl_en", 1'b1, controller_enable)
	endtask : t_hiccup
	task t_thermal;
		therm_hot <= 1'b1;
		cyc(6);
		`CHK("fault", 1'b1, thermal_fault)
		`CHK("ctl_en", 1'b0, controller_enable)
		therm_hot <= 1'b0;
		therm_cool <= 1'b1;
		vcc_fall;
		vcc_rise;
		`CHK("ctl_en", 1'b1, controller_enable)
		`CHK("fault", 1'b0, thermal_fault)
		therm_hot <= 1'b1;
		therm_cool <= 1'b0;
		cyc(6);
		`CHK("fault", 1'b1, thermal_fault)
		therm_hot <= 1'b0;
		brownout <= 1'b1;
		cyc(6);
		`CHK("fault", 1'b0, thermal_fault)
		vcc_fall;
		vcc_rise;
		`CHK("ctl_en", 1'b0, controller_enable)
		brownout <= 1'b0;
		vcc_fall;
		vcc_rise;
		`CHK("ctl_en", 1'b1, controller_enable)
	endtask : t_thermal
	// latched overload: only a supply clear level, brown-out or line removal releases it
	task t_latch;
		ahb(1'b1, REG_CTRL_ADDR, 32'h0);
		overload <= 1'b1;
		cyc(6);
		`CHK("ctl_en", 1'b0, controller_enable)
		ahb(1'b0, REG_STATUS_ADDR, 32'h0);
		`CHK("state", ST_LATCH, rd[STAT_STATE_LSB +: 3])
		overload <= 1'b0;
		vcc_fall;
		vcc_rise;
		`CHK("ctl_en", 1'b0, controller_enable)
		vcc_fall;
		vcc_below_clear <= 1'b1;
		cyc(6);
		ahb(1'b0, REG_STATUS_ADDR, 32'h0);
		`CHK("state", ST_WAIT, rd[STAT_STATE_LSB +: 3])
		vcc_below_clear <= 1'b0;
		vcc_rise;
		`CHK("ctl_en", 1'b1, controller_enable)
	endtask : t_latch
	initial
	begin
		{rst_n, ctrl_below_skip, ctrl_above_resume, pfc_in_reg, pfc_uvp, overload} = '0;
		{vcc_above_on, vcc_below_off, vcc_below_clear, therm_hot, therm_cool, brownout} = '0;
		{hwrite, opto_on, lvl_on, haddr, hwdata, htrans} = '0;
		{errors, tests_run, cycles} = '0;
		line_present = 1'b1;
		hsel = 1'b1;
		hsize = 3'h2;
		cyc(12);
		rst_n <= 1'b1;
		cyc(1);
		t_regs;
		t_start;
		t_enable;
		t_skip;
		t_hiccup;
		t_thermal;
		t_latch;
		report_and_stop;
	end
endmodule : test_pfc_enable_fault_sequencer
